// >>> design/pwl_act_latch.v
`timescale 1ns/100ps
module pwl_act_latch #(
  parameter CHANNELS = 8
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // pins and clear
  input wire [CHANNELS-1:0] pinLevel,
  input wire clearAll,
  // latched activity
  output wire [CHANNELS-1:0] activity
);
  genvar g;

  // ==================================================
  // one latch per channel
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      reg prev_reg;
      reg act_reg;
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          prev_reg <= 1'b1;
          act_reg <= 1'b0;
        end else begin
          prev_reg <= pinLevel[g];
          // a transition in the clear cycle still sets the latch
          if (prev_reg != pinLevel[g]) begin // [RQ14]
            act_reg <= 1'b1;
          end else if (clearAll) begin // [RQ15]
            act_reg <= 1'b0;
          end
        end
      end
      assign activity[g] = act_reg;
    end
  endgenerate
endmodule // pwl_act_latch

// >>> design/pwl_fifo2.v
`timescale 1ns/100ps
module pwl_fifo2 #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // filling side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // draining side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  integer i;

  assign inReady = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData = mem_reg[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // ==================================================
  // storage and pointers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_reg[wrPtr_reg] <= inData;
        wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // pwl_fifo2

// >>> design/pwl_map.vh
`ifndef PWL_MAP_VH
`define PWL_MAP_VH
// Function
// RQ1: output latches change only by channel-access write and drive the eight open-drain outputs.
// RQ2: channel-access write loops: take new data, then return sampled pin status.
// RQ3: data byte follows command; bit 0 is channel zero; 1 releases, 0 pulls low.
// RQ4: inverted copy must follow; outputs change only on an exact inverse.
// RQ5: update at last inverse bit: after sample delay if 1, at slot end if 0.
// RQ6: after a good update the device sends the alternating confirmation byte.
// RQ7: in strobe mode, strobe pulses during the two low confirmation bits; the code holds it over the first two bits, 0 then 1.
// RQ8: pins sampled during last confirmation bit, then sent; master writes again or resets.
// RQ9: reset-input mode held low forces outputs off and latches read all ones.
// RQ10: register write takes a two-byte target; only the three search registers accepted.
// RQ11: valid target: each byte stored at once, next byte to next address.
// RQ12: after control/status is written, further bytes are ignored until bus reset.
// RQ13: master should read registers back, since the write has no error check.
// RQ14: each channel has an activity latch set by any pin transition.
// RQ15: activity latches are read-only; the reset command clears all eight together.
// RQ16: after activity reset, every read byte is the confirmation pattern until reset.
// RQ17: a bus reset aborts channel-access write at any point.
// RQ18: one master; this device is always slave; master starts every slot.
// RQ19: master leaves an idle line high and keeps lows within the reset limits.
// RQ20: up to 15.3 kbps standard speed, at most 100 kbps overdrive.
// RQ21: every party drives the shared line only open-drain or tri-state.
// RQ22: control/status bit 2 picks the pin function: 0 reset input, 1 strobe.
// RQ23: a mismatched inverse leaves outputs unchanged, no confirmation, wait for bus reset.

// ==================================================
// command codes
`define PWL_CMD_CHAN_WRITE 8'h5a
`define PWL_CMD_SEARCH_WRITE 8'hcc
`define PWL_CMD_ACT_RESET 8'hc3
`define PWL_CONFIRM 8'haa

// ==================================================
// register locations
`define PWL_ADDR_OUT_LATCH 16'h0089
`define PWL_ADDR_ACT_LATCH 16'h008a
`define PWL_ADDR_SEARCH_MASK 16'h008b
`define PWL_ADDR_SEARCH_POL 16'h008c
`define PWL_ADDR_CTRL 16'h008d

// ==================================================
// control/status fields and reset values
`define PWL_CTRL_PLS 0
`define PWL_CTRL_CT 1
`define PWL_CTRL_PINSEL 2
`define PWL_CTRL_PORL 3
`define PWL_CTRL_VCCP 7
`define PWL_CTRL_WMASK 8'h07
`define PWL_CTRL_RESET 8'h08
`define PWL_OUT_LATCH_RESET 8'hff
`define PWL_SEARCH_RESET 8'h00
`endif

// >>> design/pwl_top.v
`timescale 1ns/100ps
`include "pwl_map.vh"
module pwl_top #(
  parameter CHANNELS = 8
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // bit-slot events from the line front end
  input wire cmdStart,
  input wire busReset,
  input wire slotSample,
  input wire rxBit,
  input wire slotEnd,
  output reg txBit,
  output reg rxReady,
  // port pins
  input wire [CHANNELS-1:0] portIn,
  output reg [CHANNELS-1:0] portOut,
  output reg [CHANNELS-1:0] portOe,
  // reset or strobe pin
  input wire rstStrbIn,
  output reg rstStrbOut,
  output reg rstStrbOe,
  // supply status
  input wire vccPowered,
  // register contents
  output reg [CHANNELS-1:0] outputLatchState,
  output reg [CHANNELS-1:0] activityLatchState,
  output reg [7:0] searchChannelMask,
  output reg [7:0] searchPolaritySelect,
  output reg [7:0] controlAndStatus
);
  localparam S_IDLE = 4'd0;
  localparam S_CMD = 4'd1;
  localparam S_CAW_DATA = 4'd2;
  localparam S_CAW_INV = 4'd3;
  localparam S_CAW_CONF = 4'd4;
  localparam S_CAW_STAT = 4'd5;
  localparam S_CSR_ADDR = 4'd6;
  localparam S_CSR_DATA = 4'd7;
  localparam S_ACT_CONF = 4'd8;
  localparam S_HALT = 4'd9;
  localparam [7:0] CTRL_INIT = `PWL_CTRL_RESET;
  localparam [7:0] CONF_PAT = `PWL_CONFIRM;

  reg [3:0] state_reg;
  reg [2:0] bitCnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] newData_reg;
  reg [7:0] status_reg;
  reg [15:0] addr_reg;
  reg addrHigh_reg;
  reg matched_reg;
  reg applyPending_reg;
  reg strobeOn_reg;
  reg [7:0] latch_reg;
  reg [7:0] mask_reg;
  reg [7:0] pol_reg;
  reg [3:0] ctrl_reg;
  reg actClear_reg;
  wire [7:0] rxByte;
  wire [7:0] fifoData;
  wire fifoValid;
  wire fifoInReady;
  wire fifoPop;
  wire rxState;
  wire [7:0] actNow;
  wire pinMode;
  wire latchForced;
  wire [7:0] candidate;

  // ==================================================
  // helpers
  function is_rx_state;
    input [3:0] st;
    begin
      is_rx_state = (st == S_CMD) || (st == S_CAW_DATA) || (st == S_CAW_INV) ||
        (st == S_CSR_ADDR) || (st == S_CSR_DATA);
    end
  endfunction

  function search_addr_ok;
    input [15:0] a;
    begin
      search_addr_ok = (a >= `PWL_ADDR_SEARCH_MASK) && (a <= `PWL_ADDR_CTRL); // [RQ10]
    end
  endfunction

  assign rxState = is_rx_state(state_reg);
  assign rxByte = {rxBit, shift_reg[7:1]};
  assign candidate = rxByte;
  assign pinMode = ctrl_reg[`PWL_CTRL_PINSEL]; // [RQ22]
  // reset-input mode with the pin low holds the outputs off
  assign latchForced = !pinMode && !rstStrbIn; // [RQ9]
  assign fifoPop = fifoValid && rxState;

  // ==================================================
  // received byte buffer; a full buffer holds off the front end
  // two entries absorb a byte at either line rate [RQ20]
  pwl_fifo2 #(
    .WIDTH(8),
    .DEPTH(2),
    .AW(1)
  ) u_rxbuf (
    .clk(clk),
    .reset(reset),
    .inValid(rxState && slotEnd && (bitCnt_reg == 3'd7)),
    .inReady(fifoInReady),
    .inData(shift_reg),
    .outValid(fifoValid),
    .outReady(rxState),
    .outData(fifoData)
  );

  pwl_act_latch #(
    .CHANNELS(CHANNELS)
  ) u_act (
    .clk(clk),
    .reset(reset),
    .pinLevel(portIn),
    .clearAll(actClear_reg),
    .activity(actNow)
  );

  // ==================================================
  // command sequencer
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= S_IDLE;
      bitCnt_reg <= 3'd0;
      shift_reg <= 8'h00;
      newData_reg <= 8'h00;
      status_reg <= 8'h00;
      addr_reg <= 16'h0000;
      addrHigh_reg <= 1'b0;
      matched_reg <= 1'b0;
      applyPending_reg <= 1'b0;
      strobeOn_reg <= 1'b0;
      latch_reg <= `PWL_OUT_LATCH_RESET;
      mask_reg <= `PWL_SEARCH_RESET;
      pol_reg <= `PWL_SEARCH_RESET;
      ctrl_reg <= CTRL_INIT[3:0];
      actClear_reg <= 1'b0;
      txBit <= 1'b1;
    end else begin
      actClear_reg <= 1'b0;
      if (latchForced) begin
        latch_reg <= 8'hff; // [RQ9]
      end
      if (busReset) begin
        // any bus reset ends the running command
        state_reg <= S_IDLE; // [RQ17]
        bitCnt_reg <= 3'd0;
        applyPending_reg <= 1'b0;
        strobeOn_reg <= 1'b0;
        matched_reg <= 1'b0;
        txBit <= 1'b1;
      end else if (cmdStart && state_reg == S_IDLE) begin
        state_reg <= S_CMD;
        bitCnt_reg <= 3'd0;
      end else begin
        // ----- bit level: receive shift
        if (rxState && slotSample) begin // [RQ18]
          shift_reg <= rxByte; // [RQ3]
          if (state_reg == S_CAW_INV && bitCnt_reg == 3'd7) begin
            matched_reg <= (candidate == ~newData_reg); // [RQ4]
            if (candidate == ~newData_reg) begin
              if (rxBit) begin
                if (!latchForced) begin
                  latch_reg <= newData_reg; // [RQ5] [RQ1]
                end
              end else begin
                applyPending_reg <= 1'b1; // [RQ5]
              end
            end
          end
        end
        if (applyPending_reg && slotEnd) begin
          applyPending_reg <= 1'b0;
          if (!latchForced) begin
            latch_reg <= newData_reg; // [RQ5] [RQ1]
          end
        end
        // ----- bit level: transmit states
        if (state_reg == S_CAW_CONF || state_reg == S_CAW_STAT || state_reg == S_ACT_CONF) begin
          if (state_reg == S_CAW_CONF && slotSample && bitCnt_reg == 3'd7) begin
            status_reg <= portIn; // [RQ8]
          end
          if (slotEnd) begin
            bitCnt_reg <= bitCnt_reg + 3'd1;
            if (state_reg == S_CAW_CONF && bitCnt_reg == 3'd1) begin
              strobeOn_reg <= 1'b0; // [RQ7]
            end
            if (bitCnt_reg == 3'd7) begin
              case (state_reg)
                S_CAW_CONF: begin
                  state_reg <= S_CAW_STAT; // [RQ8]
                  txBit <= status_reg[0];
                end
                S_CAW_STAT: begin
                  state_reg <= S_CAW_DATA; // [RQ2]
                  txBit <= 1'b1;
                end
                default: begin
                  txBit <= CONF_PAT[0]; // [RQ16]
                end
              endcase
            end else begin
              case (state_reg)
                S_CAW_STAT: txBit <= status_reg[bitCnt_reg + 3'd1];
                default: txBit <= CONF_PAT[bitCnt_reg + 3'd1]; // [RQ6] [RQ16]
              endcase
            end
          end
        end else if (rxState && slotEnd) begin
          bitCnt_reg <= bitCnt_reg + 3'd1;
        end
        // ----- byte level
        if (fifoPop) begin
          case (state_reg)
            S_CMD: begin
              case (fifoData)
                `PWL_CMD_CHAN_WRITE: state_reg <= S_CAW_DATA;
                `PWL_CMD_SEARCH_WRITE: begin
                  state_reg <= S_CSR_ADDR;
                  addrHigh_reg <= 1'b0;
                end
                `PWL_CMD_ACT_RESET: begin
                  actClear_reg <= 1'b1; // [RQ15]
                  state_reg <= S_ACT_CONF;
                  bitCnt_reg <= 3'd0;
                  txBit <= 1'b0; // [RQ16]
                end
                default: state_reg <= S_HALT;
              endcase
            end
            S_CAW_DATA: begin
              newData_reg <= fifoData; // [RQ3]
              state_reg <= S_CAW_INV;
            end
            S_CAW_INV: begin
              if (matched_reg) begin
                state_reg <= S_CAW_CONF; // [RQ6]
                bitCnt_reg <= 3'd0;
                txBit <= 1'b0;
                strobeOn_reg <= pinMode; // [RQ7]
              end else begin
                state_reg <= S_HALT; // [RQ23]
              end
            end
            S_CSR_ADDR: begin
              if (!addrHigh_reg) begin
                addr_reg[7:0] <= fifoData;
                addrHigh_reg <= 1'b1;
              end else begin
                addr_reg[15:8] <= fifoData;
                if (!search_addr_ok({fifoData, addr_reg[7:0]})) begin
                  state_reg <= S_HALT; // [RQ10]
                end else begin
                  state_reg <= S_CSR_DATA;
                end
              end
            end
            S_CSR_DATA: begin
              // written as each byte arrives; no check, master reads back
              case (addr_reg)
                `PWL_ADDR_SEARCH_MASK: mask_reg <= fifoData; // [RQ11]
                `PWL_ADDR_SEARCH_POL: pol_reg <= fifoData; // [RQ11]
                default: begin
                  // power-on flag can only be cleared, never set
                  ctrl_reg <= {ctrl_reg[3] & fifoData[`PWL_CTRL_PORL], fifoData[2:0]};
                end
              endcase
              addr_reg <= addr_reg + 16'h0001; // [RQ11]
              if (addr_reg == `PWL_ADDR_CTRL) begin
                state_reg <= S_HALT; // [RQ12]
              end
            end
            default: state_reg <= S_HALT;
          endcase
        end
      end
    end
  end

  // ==================================================
  // registered outputs
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      portOut <= {CHANNELS{1'b0}};
      portOe <= {CHANNELS{1'b0}};
      rstStrbOut <= 1'b0;
      rstStrbOe <= 1'b0;
      rxReady <= 1'b1;
      outputLatchState <= `PWL_OUT_LATCH_RESET;
      activityLatchState <= 8'h00;
      searchChannelMask <= `PWL_SEARCH_RESET;
      searchPolaritySelect <= `PWL_SEARCH_RESET;
      controlAndStatus <= `PWL_CTRL_RESET;
    end else begin
      portOut <= {CHANNELS{1'b0}}; // [RQ21]
      // a zero latch bit turns its pull-down on
      portOe <= latchForced ? {CHANNELS{1'b0}} : ~latch_reg; // [RQ1] [RQ9]
      rstStrbOut <= 1'b0; // [RQ21]
      rstStrbOe <= strobeOn_reg && pinMode; // [RQ7]
      rxReady <= fifoInReady;
      outputLatchState <= latch_reg;
      activityLatchState <= actNow; // [RQ14]
      searchChannelMask <= mask_reg;
      searchPolaritySelect <= pol_reg;
      controlAndStatus <= {vccPowered, 3'b000, ctrl_reg};
    end
  end
endmodule // pwl_top

// >>> tb/pwl_bus_master.sv
`timescale 1ns/100ps
// ==================================================
// line master: starts every slot
module pwl_bus_master (
  // clock
  input wire clk,
  // slot events
  output reg cmdStart,
  output reg busReset,
  output reg slotSample,
  output reg rxBit,
  output reg slotEnd,
  // device answer
  input wire txBit,
  input wire rxReady
);
  integer waitFails = 0;
  integer gap = 2;
  initial {cmdStart, busReset, slotSample, slotEnd, rxBit} = 5'h01;
  task slot(input reg wb, output reg rb);
    integer n;
    begin
      @(negedge clk);
      slotSample = 1'b1;
      rxBit = wb & txBit; // wired and on the line
      @(negedge clk);
      slotSample = 1'b0;
      rb = txBit;
      repeat (gap) @(negedge clk);
      // a full buffer stalls the slot end rather than losing a byte
      for (n = 0; rxReady !== 1'b1 && n < 100; n = n + 1) @(negedge clk);
      if (n == 100) waitFails = waitFails + 1;
      slotEnd = 1'b1;
      @(negedge clk);
      slotEnd = 1'b0;
      rxBit = 1'b1; // idle high between slots
      repeat (4) @(negedge clk);
    end
  endtask
  task wbyte(input reg [7:0] b);
    integer i;
    reg r;
    begin
      for (i = 0; i < 8; i = i + 1) slot(b[i], r);
    end
  endtask
  task rbyte(output reg [7:0] b);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) slot(1'b1, b[i]);
    end
  endtask
  task cmd(input reg [7:0] c);
    begin
      @(negedge clk);
      busReset = 1'b1;
      @(negedge clk);
      busReset = 1'b0;
      cmdStart = 1'b1;
      @(negedge clk);
      cmdStart = 1'b0;
      wbyte(c);
    end
  endtask
endmodule // pwl_bus_master

// >>> tb/pwl_top_assertions.sv
`timescale 1ns/100ps
// ==================================================
// pin and register checks
module pwl_top_assertions #(
  parameter CHANNELS = 8
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // slot events
  input wire busReset,
  input wire slotSample,
  input wire slotEnd,
  input wire txBit,
  // pins
  input wire [CHANNELS-1:0] portIn,
  input wire [CHANNELS-1:0] portOut,
  input wire [CHANNELS-1:0] portOe,
  input wire rstStrbIn,
  input wire rstStrbOut,
  input wire rstStrbOe,
  // registers
  input wire [CHANNELS-1:0] outputLatchState,
  input wire [CHANNELS-1:0] activityLatchState,
  input wire [7:0] searchChannelMask,
  input wire [7:0] controlAndStatus
);
  reg [CHANNELS-1:0] prevPin;
  // a low reset pin counts as a cause, since it forces the latch
  wire slotAct = slotSample | slotEnd | ~rstStrbIn;
  always @(posedge clk) prevPin <= portIn;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_open_drain_low: assert property (portOut == 0 && !rstStrbOut) else $error("pin driven high");
  a_latch_needs_slot: assert property (!$stable(outputLatchState) |->
    $past(slotAct) || $past(slotAct, 2) || $past(slotAct, 3)) else $error("latch moved alone");
  a_oe_follows_latch: assert property (!$stable(outputLatchState) |=>
    portOe == ~$past(outputLatchState)) else $error("drive not latch");
  a_strobe_needs_mode: assert property (rstStrbOe |-> controlAndStatus[2]) else $error("strobe in reset mode");
  a_strobe_ends: assert property ($rose(rstStrbOe) |-> ##[1:1000] !rstStrbOe) else $error("strobe stuck");
  a_act_clear_all: assert property ((($past(activityLatchState) & ~activityLatchState) != 0) |->
    activityLatchState == 0) else $error("partial clear");
  a_act_sets: assert property ((portIn != prevPin) |-> ##[1:4] activityLatchState != 0) else $error("no activity");
  a_tx_steady: assert property (slotSample |-> $stable(txBit) ##1 $stable(txBit)) else $error("tx moved");
  a_reset_silent: assert property (busReset |-> ##[1:2] txBit) else $error("tx after reset");
  a_mask_on_byte: assert property (!$stable(searchChannelMask) |->
    $past(slotEnd, 2) || $past(slotEnd, 3) || $past(slotEnd, 4)) else $error("mask moved alone");
  a_ctrl_zero_bits: assert property (controlAndStatus[6:4] == 3'h0) else $error("ctrl bits set");
endmodule // pwl_top_assertions

// >>> tb/pwl_top_tb.sv
`timescale 1ns/100ps
// ==================================================
// bench top
module pwl_top_tb;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg vccPowered = 1'b1;
  reg strbPull = 1'b1;
  reg [7:0] extPins = 8'hff;
  wire cmdStart, busReset, slotSample, rxBit, slotEnd, txBit, rxReady, rstStrbOut, rstStrbOe;
  wire [7:0] portOut, portOe, outputLatchState, activityLatchState;
  wire [7:0] searchChannelMask, searchPolaritySelect, controlAndStatus;
  wire [7:0] portIn = extPins & ~portOe;
  wire rstStrbIn = strbPull & ~rstStrbOe;
  integer num_errors = 0;
  integer total_checks = 0;
  integer strbCycles = 0;
  integer i;
  reg b;
  reg [7:0] rd;
  always #25 clk = ~clk;
  always @(posedge clk) if (rstStrbOe) strbCycles = strbCycles + 1;
  pwl_top dut (
    .clk(clk),
    .reset(reset),
    .cmdStart(cmdStart),
    .busReset(busReset),
    .slotSample(slotSample),
    .rxBit(rxBit),
    .slotEnd(slotEnd),
    .txBit(txBit),
    .rxReady(rxReady),
    .portIn(portIn),
    .portOut(portOut),
    .portOe(portOe),
    .rstStrbIn(rstStrbIn),
    .rstStrbOut(rstStrbOut),
    .rstStrbOe(rstStrbOe),
    .vccPowered(vccPowered),
    .outputLatchState(outputLatchState),
    .activityLatchState(activityLatchState),
    .searchChannelMask(searchChannelMask),
    .searchPolaritySelect(searchPolaritySelect),
    .controlAndStatus(controlAndStatus)
  );
  pwl_bus_master master (.clk(clk), .cmdStart(cmdStart), .busReset(busReset), .slotSample(slotSample),
    .rxBit(rxBit), .slotEnd(slotEnd), .txBit(txBit), .rxReady(rxReady));
  task check(input string what, input [7:0] exp, input [7:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task chan_write(input [7:0] d);
    begin
      master.wbyte(d);
      master.wbyte(~d);
      master.rbyte(rd);
      check("confirm", 8'haa, rd);
      check("latch", d, outputLatchState);
      check("pins", d, portIn);
      master.rbyte(rd);
      check("status", d, rd);
    end
  endtask
  task clear_act;
    begin
      master.cmd(8'hc3);
      master.rbyte(rd);
      check("actconf", 8'haa, rd);
      master.rbyte(rd);
      check("actconf", 8'haa, rd);
      check("activity", 8'h00, activityLatchState);
    end
  endtask
  task print_verdict;
    begin
      num_errors = num_errors + master.waitFails;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    num_errors = num_errors + 1;
    print_verdict;
  end
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check("latch", 8'hff, outputLatchState);
    check("mask", 8'h00, searchChannelMask);
    check("ctrl", 8'h88, controlAndStatus);
    check("drive", 8'h00, portOe);
    clear_act;
    master.cmd(8'hcc);
    master.wbyte(8'h8b);
    master.wbyte(8'h00);
    master.wbyte(8'h11);
    master.wbyte(8'h22);
    master.wbyte(8'h07);
    master.wbyte(8'h55);
    repeat (4) @(negedge clk);
    check("mask", 8'h11, searchChannelMask);
    check("pol", 8'h22, searchPolaritySelect);
    check("ctrl", 8'h87, controlAndStatus);
    // read-only target below the window is refused
    master.cmd(8'hcc);
    master.wbyte(8'h8a);
    master.wbyte(8'h00);
    master.wbyte(8'h33);
    repeat (4) @(negedge clk);
    check("badaddr", 8'h11, searchChannelMask);
    check("activity", 8'h00, activityLatchState);
    master.cmd(8'h5a);
    chan_write(8'h3c);
    chan_write(8'ha5);
    check("strobe", 8'h01, {7'h0, strbCycles > 0});
    check("activity", 8'hdb, activityLatchState);
    master.cmd(8'h5a);
    master.wbyte(8'h0f);
    master.wbyte(8'hf1);
    master.rbyte(rd);
    check("silent", 8'hff, rd);
    check("latch", 8'ha5, outputLatchState);
    clear_act;
    // reset-input mode with the pin low
    master.cmd(8'hcc);
    master.wbyte(8'h8d);
    master.wbyte(8'h00);
    master.wbyte(8'h00);
    strbPull = 1'b0;
    repeat (4) @(negedge clk);
    check("forced", 8'hff, outputLatchState);
    check("drive", 8'h00, portOe);
    check("ctrl", 8'h80, controlAndStatus);
    vccPowered = 1'b0;
    repeat (2) @(negedge clk);
    check("vcc", 8'h00, controlAndStatus);
    vccPowered = 1'b1;
    strbPull = 1'b1;
    master.gap = 12;
    master.cmd(8'h5a);
    chan_write(8'h0f);
    master.gap = 2;
    master.cmd(8'h5a);
    master.wbyte(8'h00);
    for (i = 0; i < 4; i = i + 1) master.slot(1'b1, b);
    clear_act;
    check("abort", 8'h0f, outputLatchState);
    // an outside signal pulls channel zero low
    extPins = 8'hfe;
    repeat (4) @(negedge clk);
    check("extact", 8'h01, activityLatchState);
    print_verdict;
  end
endmodule // pwl_top_tb
bind pwl_top pwl_top_assertions #(.CHANNELS(CHANNELS)) chk (
  .clk(clk),
  .reset(reset),
  .busReset(busReset),
  .slotSample(slotSample),
  .slotEnd(slotEnd),
  .txBit(txBit),
  .portIn(portIn),
  .portOut(portOut),
  .portOe(portOe),
  .rstStrbIn(rstStrbIn),
  .rstStrbOut(rstStrbOut),
  .rstStrbOe(rstStrbOe),
  .outputLatchState(outputLatchState),
  .activityLatchState(activityLatchState),
  .searchChannelMask(searchChannelMask),
  .controlAndStatus(controlAndStatus)
);
